// ==== fla_interval.sv ====
// Top: interval setting register and adjustment gating
//
// Notes on behaviour
// - Bits 2:0 set remote one wait
// - Decrease wait 8 doubling to 1024
// - Increase wait 16 doubling to 2048
// - Wait counted in 125 ms cycles
// - Bits 5:3 set remote two wait
// - Bit 6 selects loop, default newer
// - Reset value 0x40, writes blocked when locked
`timescale 1ns/1ps
module fla_interval (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        sw_reset_i,
   input  wire logic        lock_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        write_i,
   input  wire logic        read_i,
   output logic      [7:0]  rdata_o,
   input  wire logic        r1_adjust_i,
   input  wire logic        r2_adjust_i,
   output logic             r1_dec_ok_o,
   output logic             r1_inc_ok_o,
   output logic             r2_dec_ok_o,
   output logic             r2_inc_ok_o,
   output logic             new_loop_sel_o,
   output logic             mon_tick_o
);
   logic [7:0]  ctrl_q;
   logic [7:0]  rdata_q;
   logic [22:0] div_q;
   logic        tick_q;
   logic [2:0]  remote_one_interval_code;
   logic [2:0]  remote_two_interval_code;

   // ----------------------------------------
   // Setting register
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i || sw_reset_i) begin
         ctrl_q <= fla_pkg::FLOOR_CTRL_2_RESET;
      end else if (write_i && !lock_i && addr_i == fla_pkg::ADDR_FLOOR_CTRL_2) begin
         ctrl_q <= wdata_i & fla_pkg::FLOOR_CTRL_2_WMASK;
      end
   end

   assign remote_one_interval_code = ctrl_q[fla_pkg::R1_CODE_LSB +: 3];
   assign remote_two_interval_code = ctrl_q[fla_pkg::R2_CODE_LSB +: 3];
   assign new_loop_sel_o           = ctrl_q[fla_pkg::LOOP_SEL_BIT];

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata_q <= 8'h00;
      end else if (read_i) begin
         unique case (addr_i)
            fla_pkg::ADDR_FLOOR_CTRL_2: rdata_q <= ctrl_q;
            fla_pkg::ADDR_LOOP_STATUS:  rdata_q <= {4'h0, r2_inc_ok_o, r2_dec_ok_o,
                                                    r1_inc_ok_o, r1_dec_ok_o};
            default:                    rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign rdata_o = rdata_q;

   // ----------------------------------------
   // Monitoring cycle tick
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         div_q  <= 23'h000000;
         tick_q <= 1'b0;
      end else if (div_q == 23'(fla_pkg::MON_TICK_CLKS - 1)) begin
         div_q  <= 23'h000000;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 23'h000001;
         tick_q <= 1'b0;
      end
   end
   assign mon_tick_o = tick_q;

   // ----------------------------------------
   // Channel timers
   // ----------------------------------------
   fla_channel_timer u_r1 (
      .clk_i     (clk_i),
      .reset_i   (reset_i),
      .tick_i    (tick_q),
      .code_i    (remote_one_interval_code),
      .adjust_i  (r1_adjust_i),
      .dec_ok_o  (r1_dec_ok_o),
      .inc_ok_o  (r1_inc_ok_o),
      .elapsed_o ()
   );

   fla_channel_timer u_r2 (
      .clk_i     (clk_i),
      .reset_i   (reset_i),
      .tick_i    (tick_q),
      .code_i    (remote_two_interval_code),
      .adjust_i  (r2_adjust_i),
      .dec_ok_o  (r2_dec_ok_o),
      .inc_ok_o  (r2_inc_ok_o),
      .elapsed_o ()
   );
endmodule

// ==== fla_pkg.sv ====
// Package: constants for the fan loop adjust interval block
package fla_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_FLOOR_CTRL_2  = 8'h0C;
   localparam logic [7:0] ADDR_LOOP_STATUS   = 8'h0E;
   localparam logic [7:0] FLOOR_CTRL_2_RESET = 8'h40;
   localparam logic [7:0] FLOOR_CTRL_2_WMASK = 8'h7F;
   localparam int         R1_CODE_LSB        = 0;
   localparam int         R2_CODE_LSB        = 3;
   localparam int         LOOP_SEL_BIT       = 6;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int          CLK_HZ            = 20000000;
   localparam int          MON_CYCLE_MS      = 125;
   localparam int          MON_TICK_CLKS     = CLK_HZ / 1000 * MON_CYCLE_MS;
   localparam logic [11:0] DEC_BASE_CYCLES   = 12'h008;
   localparam logic [11:0] INC_BASE_CYCLES   = 12'h010;
   localparam int          CNT_W             = 12;
endpackage

// ==== fla_channel_timer.sv ====
// Per-channel adjustment wait counter
`timescale 1ns/1ps
module fla_channel_timer (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        tick_i,
   input  wire logic [2:0]  code_i,
   input  wire logic        adjust_i,
   output logic             dec_ok_o,
   output logic             inc_ok_o,
   output logic [11:0]      elapsed_o
);
   logic [11:0] cnt_q;
   logic [11:0] dec_lim;
   logic [11:0] inc_lim;

   // ----------------------------------------
   // Limits from code
   // ----------------------------------------
   assign dec_lim = fla_pkg::DEC_BASE_CYCLES << code_i;
   assign inc_lim = fla_pkg::INC_BASE_CYCLES << code_i;

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cnt_q <= 12'h000;
      end else if (adjust_i) begin
         cnt_q <= 12'h000;
      end else if (tick_i && cnt_q != 12'hFFF) begin
         cnt_q <= cnt_q + 12'h001;
      end
   end

   assign dec_ok_o  = cnt_q >= dec_lim;
   assign inc_ok_o  = cnt_q >= inc_lim;
   assign elapsed_o = cnt_q;
endmodule

// ==== fla_interval_asserts.sv ====
// Checker for the interval block ports
`timescale 1ns/1ps
module fla_interval_chk (
   input wire logic       clk_i,
   input wire logic       reset_i,
   input wire logic       sw_reset_i,
   input wire logic       lock_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       write_i,
   input wire logic       read_i,
   input wire logic [7:0] rdata_o,
   input wire logic       r1_adjust_i,
   input wire logic       r2_adjust_i,
   input wire logic       r1_dec_ok_o,
   input wire logic       r1_inc_ok_o,
   input wire logic       r2_dec_ok_o,
   input wire logic       r2_inc_ok_o,
   input wire logic       new_loop_sel_o,
   input wire logic       mon_tick_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic wr_ok;
   assign wr_ok = write_i && addr_i == 8'h0C && !lock_i && !sw_reset_i;
   a_rdata_idle: assert property (!$past(read_i) |-> rdata_o == 8'h00) else $error("rdata not 0");
   a_tick_pulse: assert property (mon_tick_o |=> !mon_tick_o) else $error("tick too long");
   a_r1_restart: assert property (r1_adjust_i |=> !r1_dec_ok_o && !r1_inc_ok_o)
      else $error("r1 not restarted");
   a_r2_restart: assert property (r2_adjust_i |=> !r2_dec_ok_o && !r2_inc_ok_o)
      else $error("r2 not restarted");
   a_r1_order: assert property (r1_inc_ok_o |-> r1_dec_ok_o) else $error("r1 order");
   a_r2_order: assert property (r2_inc_ok_o |-> r2_dec_ok_o) else $error("r2 order");
   a_sel_write: assert property (wr_ok |=> new_loop_sel_o == $past(wdata_i[6]))
      else $error("select not written");
   a_lock_hold: assert property (write_i && lock_i && !sw_reset_i |=> $stable(new_loop_sel_o))
      else $error("locked write landed");
   a_sw_default: assert property (sw_reset_i |=> new_loop_sel_o) else $error("sw reset");
endmodule
bind fla_interval fla_interval_chk i_chk (.clk_i(clk_i), .reset_i(reset_i),
   .sw_reset_i(sw_reset_i), .lock_i(lock_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .r1_adjust_i(r1_adjust_i),
   .r2_adjust_i(r2_adjust_i), .r1_dec_ok_o(r1_dec_ok_o), .r1_inc_ok_o(r1_inc_ok_o),
   .r2_dec_ok_o(r2_dec_ok_o), .r2_inc_ok_o(r2_inc_ok_o),
   .new_loop_sel_o(new_loop_sel_o), .mon_tick_o(mon_tick_o));

// ==== fla_interval_test.sv ====
// Testbench for the interval block
`timescale 1ns/1ps
module fla_interval_test;
   logic       clk_i = 0, reset_i = 1, sw_reset_i = 0, lock_i = 0, write_i = 0, read_i = 0;
   logic       r1_adjust_i = 0, r2_adjust_i = 0, r1_dec_ok_o, r1_inc_ok_o, r2_dec_ok_o;
   logic       r2_inc_ok_o, new_loop_sel_o, mon_tick_o;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
   int         n_mismatch = 0, comparisons = 0, cycles = 0;
   always #25 clk_i = ~clk_i;
   fla_interval i_dut (.clk_i(clk_i), .reset_i(reset_i), .sw_reset_i(sw_reset_i),
      .lock_i(lock_i), .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i),
      .read_i(read_i), .rdata_o(rdata_o), .r1_adjust_i(r1_adjust_i),
      .r2_adjust_i(r2_adjust_i), .r1_dec_ok_o(r1_dec_ok_o), .r1_inc_ok_o(r1_inc_ok_o),
      .r2_dec_ok_o(r2_dec_ok_o), .r2_inc_ok_o(r2_inc_ok_o),
      .new_loop_sel_o(new_loop_sel_o), .mon_tick_o(mon_tick_o));
   task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk_i);
      write_i <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge clk_i);
      write_i <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] exp, string name);
      @(posedge clk_i);
      read_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      read_i <= 1'b0;
      #1 chk(name, exp, rdata_o);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         stop_test();
      end
   end
   initial begin
      repeat (6) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(8'h0C, 8'h40, "reset value");
      chk("loop select", 8'h01, {7'h00, new_loop_sel_o});
      for (int i = 0; i < 8; i++) begin
         wr(8'h0C, 8'h80 | 8'(i * 9));
         rd(8'h0C, 8'(i * 9), "both codes");
      end
      chk("loop select", 8'h00, {7'h00, new_loop_sel_o});
      $display("test codes done");
      @(posedge clk_i);
      lock_i <= 1'b1;
      wr(8'h0C, 8'h45);
      rd(8'h0C, 8'h3F, "locked write");
      @(posedge clk_i);
      lock_i     <= 1'b0;
      sw_reset_i <= 1'b1;
      @(posedge clk_i);
      sw_reset_i <= 1'b0;
      rd(8'h0C, 8'h40, "software reset");
      $display("test lock and reset done");
      @(posedge clk_i);
      r1_adjust_i <= 1'b1;
      r2_adjust_i <= 1'b1;
      @(posedge clk_i);
      r1_adjust_i <= 1'b0;
      r2_adjust_i <= 1'b0;
      rd(8'h0E, 8'h00, "wait status");
      chk("ok flags", 8'h00, {4'h0, r2_inc_ok_o, r2_dec_ok_o, r1_inc_ok_o, r1_dec_ok_o});
      chk("tick idle", 8'h00, {7'h00, mon_tick_o});
      rd(8'h10, 8'h00, "unmapped");
      $display("test adjust done");
      stop_test();
   end
endmodule
